// ---- hw/nsx_pkg.sv ----
// Package for the nibble-exchange / xor / direction-load datapath.
// Assumes one core clock and an 8-bit data path.
package nsx_pkg;
	localparam int DataWidth = 8;
	localparam int FileAddrWidth = 7;
	localparam int PortSelWidth = 3;
	localparam logic [7:0] WorkResetValue = 8'h00;
	localparam logic [7:0] DirResetValue = 8'hFF;
	localparam logic [7:0] ZeroValue = 8'h00;
	localparam logic DestWork = 1'b0;
	localparam logic DestFile = 1'b1;
	localparam logic [2:0] PortASel = 3'h5;
	localparam logic [2:0] PortBSel = 3'h6;
	localparam logic [2:0] PortCSel = 3'h7;
	localparam int NibbleLowMsb = 3;
	localparam int NibbleHighLsb = 4;
	localparam int NibbleHighMsb = 7;

	typedef enum logic [1:0] {
		nibble_exchange_op,
		xor_literal_op,
		xor_file_op,
		direction_load_op
	} nsx_op_type;

	typedef struct packed {
		logic [7:0] work;
		logic zero;
		logic [7:0] portADir;
		logic [7:0] portBDir;
		logic [7:0] portCDir;
		logic fileWe;
		logic [6:0] fileWaddr;
		logic [7:0] fileWdata;
	} nsx_state_type;
endpackage

// ---- hw/nsx_datapath.sv ----
// Execution datapath for four core instructions: nibble exchange, xor with
// literal, xor with file register, and port direction load.
// Assumes the decoder presents opValid with the file register read data already
// valid in the same cycle, and that the register file takes the write one cycle later.
//
// Overview of operation
// RULE_01 - Nibble exchange moves source bits 3:0 to result 7:4 and 7:4 to 3:0, flags untouched.
// RULE_02 - Destination bit 0 sends the result to the working register, 1 back to the file register.
// RULE_03 - Literal xor combines the working register with an 8-bit literal into the working register and updates zero.
// RULE_04 - File xor combines the working register with the addressed file register, routes by destination, updates zero.
// RULE_05 - Direction load copies the working register into port A, B or C direction for operand 5, 6 or 7, flags untouched.
// RULE_06 - Where zero is affected it is set for a zero result and cleared otherwise.
`timescale 1ns/1ps
module nsx_datapath
	import nsx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic opValid,
	input wire nsx_pkg::nsx_op_type opCode,
	input wire logic destSel,
	input wire logic [nsx_pkg::FileAddrWidth-1:0] fileAddr,
	input wire logic [nsx_pkg::DataWidth-1:0] literalValue,
	input wire logic [nsx_pkg::DataWidth-1:0] fileRdata,
	output logic [nsx_pkg::DataWidth-1:0] workValue,
	output logic zeroFlag,
	output logic [nsx_pkg::DataWidth-1:0] portADirection,
	output logic [nsx_pkg::DataWidth-1:0] portBDirection,
	output logic [nsx_pkg::DataWidth-1:0] portCDirection,
	output logic fileWe,
	output logic [nsx_pkg::FileAddrWidth-1:0] fileWaddr,
	output logic [nsx_pkg::DataWidth-1:0] fileWdata
);
	import nsx_pkg::*;

	nsx_state_type state_reg;
	nsx_state_type state_next;
	logic [DataWidth-1:0] result;
	logic [PortSelWidth-1:0] portSel;

	assign portSel = fileAddr[PortSelWidth-1:0];

	always_comb begin
		state_next = state_reg;
		state_next.fileWe = 1'b0;
		result = ZeroValue;
		if (opValid) begin
			unique case (opCode)
				nibble_exchange_op: begin
					result = {fileRdata[NibbleLowMsb:0],
						fileRdata[NibbleHighMsb:NibbleHighLsb]}; // see RULE_01
				end
				xor_literal_op: begin
					result = state_reg.work ^ literalValue; // see RULE_03
					state_next.work = result;
					state_next.zero = (result == ZeroValue); // see RULE_06
				end
				xor_file_op: begin
					result = state_reg.work ^ fileRdata; // see RULE_04
					state_next.zero = (result == ZeroValue); // see RULE_06
				end
				direction_load_op: begin
					// Operands outside 5..7 select nothing and are dropped silently
					if (fileAddr[FileAddrWidth-1:PortSelWidth] == '0) begin
						if (portSel == PortASel)
							state_next.portADir = state_reg.work; // see RULE_05
						else if (portSel == PortBSel)
							state_next.portBDir = state_reg.work; // see RULE_05
						else if (portSel == PortCSel)
							state_next.portCDir = state_reg.work; // see RULE_05
					end
				end
			endcase
			if (opCode == nibble_exchange_op || opCode == xor_file_op) begin
				if (destSel == DestWork) begin
					state_next.work = result; // see RULE_02
				end else begin
					state_next.fileWe = 1'b1; // see RULE_02
					state_next.fileWaddr = fileAddr;
					state_next.fileWdata = result;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg.work <= WorkResetValue;
			state_reg.zero <= 1'b0;
			// Direction registers reset to all inputs so pins float until software drives them
			state_reg.portADir <= DirResetValue;
			state_reg.portBDir <= DirResetValue;
			state_reg.portCDir <= DirResetValue;
			state_reg.fileWe <= 1'b0;
			state_reg.fileWaddr <= '0;
			state_reg.fileWdata <= ZeroValue;
		end else begin
			state_reg <= state_next;
		end
	end

	assign workValue = state_reg.work;
	assign zeroFlag = state_reg.zero;
	assign portADirection = state_reg.portADir;
	assign portBDirection = state_reg.portBDir;
	assign portCDirection = state_reg.portCDir;
	assign fileWe = state_reg.fileWe;
	assign fileWaddr = state_reg.fileWaddr;
	assign fileWdata = state_reg.fileWdata;

	// Every check looks one cycle after the take edge, where the registered result stands
	swap_result_a: assert property ( // see RULE_01
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == nibble_exchange_op && destSel == DestWork
		|=> workValue == {$past(fileRdata[NibbleLowMsb:0]),
		$past(fileRdata[NibbleHighMsb:NibbleHighLsb])}
		&& zeroFlag == $past(zeroFlag))
		else $error("nibble exchange result or flag wrong");

	swap_file_a: assert property ( // see RULE_01
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == nibble_exchange_op && destSel == DestFile
		|=> fileWdata == {$past(fileRdata[NibbleLowMsb:0]),
		$past(fileRdata[NibbleHighMsb:NibbleHighLsb])}
		&& $stable(zeroFlag))
		else $error("nibble exchange file result or flag wrong");

	dest_file_a: assert property ( // see RULE_02
		@(posedge sys_clk) disable iff (rst)
		opValid && (opCode == xor_file_op || opCode == nibble_exchange_op)
		&& destSel == DestFile
		|=> fileWe && fileWaddr == $past(fileAddr) && $stable(workValue))
		else $error("file destination not written");

	dest_work_a: assert property ( // see RULE_02
		@(posedge sys_clk) disable iff (rst)
		opValid && destSel == DestWork |=> !fileWe)
		else $error("file written for work destination");

	xor_literal_a: assert property ( // see RULE_03
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == xor_literal_op
		|=> workValue == ($past(workValue) ^ $past(literalValue)) && !fileWe)
		else $error("literal xor result wrong");

	// The literal form has no destination bit, so a stray one must not reach the file
	literal_dest_a: assert property ( // see RULE_03
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == xor_literal_op && destSel == DestFile
		|=> !fileWe && workValue == ($past(workValue) ^ $past(literalValue)))
		else $error("literal xor wrote the file register");

	xor_file_a: assert property ( // see RULE_04
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == xor_file_op && destSel == DestFile
		|=> fileWdata == ($past(workValue) ^ $past(fileRdata)))
		else $error("file xor result wrong");

	xor_file_work_a: assert property ( // see RULE_04
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == xor_file_op && destSel == DestWork
		|=> workValue == ($past(workValue) ^ $past(fileRdata)))
		else $error("file xor work result wrong");

	dir_a_load_a: assert property ( // see RULE_05
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == direction_load_op
		&& fileAddr[FileAddrWidth-1:PortSelWidth] == '0 && portSel == PortASel
		|=> portADirection == $past(workValue) && $stable(portBDirection)
		&& $stable(portCDirection))
		else $error("port A direction load wrong");

	dir_load_a: assert property ( // see RULE_05
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == direction_load_op
		&& fileAddr[FileAddrWidth-1:PortSelWidth] == '0 && portSel == PortBSel
		|=> portBDirection == $past(workValue) && $stable(portADirection)
		&& $stable(portCDirection))
		else $error("direction load wrong");

	dir_c_load_a: assert property ( // see RULE_05
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == direction_load_op
		&& fileAddr[FileAddrWidth-1:PortSelWidth] == '0 && portSel == PortCSel
		|=> portCDirection == $past(workValue) && $stable(portADirection)
		&& $stable(portBDirection))
		else $error("port C direction load wrong");

	// Catches a decode that looks at the low operand bits only
	dir_refuse_a: assert property ( // see RULE_05
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == direction_load_op
		&& (fileAddr[FileAddrWidth-1:PortSelWidth] != '0 || portSel < PortASel)
		|=> $stable(portADirection) && $stable(portBDirection)
		&& $stable(portCDirection))
		else $error("direction changed for an illegal operand");

	dir_flags_a: assert property ( // see RULE_05
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == direction_load_op
		|=> $stable(workValue) && $stable(zeroFlag) && !fileWe)
		else $error("direction load touched work, flag or file");

	zero_flag_a: assert property ( // see RULE_06
		@(posedge sys_clk) disable iff (rst)
		opValid && (opCode == xor_literal_op || opCode == xor_file_op)
		|=> zeroFlag == (($past(workValue) ^ (($past(opCode) == xor_literal_op)
		? $past(literalValue) : $past(fileRdata))) == ZeroValue))
		else $error("zero flag wrong");

	zero_set_a: assert property ( // see RULE_06
		@(posedge sys_clk) disable iff (rst)
		opValid && opCode == xor_literal_op && workValue == literalValue
		|=> zeroFlag)
		else $error("zero flag not set for a zero result");

	idle_hold_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		!opValid |=> $stable(workValue) && $stable(zeroFlag) && !fileWe)
		else $error("state changed without an operation");
endmodule // nsx_datapath

// ---- test/nsx_file_model.sv ----
// File register model that faces the datapath's file read and write ports.
// Assumes reads are answered combinationally, and a write lands at the next edge.
`timescale 1ns/1ps
module nsx_file_model (
	input wire logic sys_clk,
	input wire logic [6:0] fileAddr,
	output logic [7:0] fileRdata,
	input wire logic fileWe,
	input wire logic [6:0] fileWaddr,
	input wire logic [7:0] fileWdata
);
	logic [7:0] store [128];
	assign fileRdata = store[fileAddr];
	// Plain always, since the bench preloads entries into the same array
	always @(posedge sys_clk) begin
		if (fileWe) begin
			store[fileWaddr] <= fileWdata;
		end
	end
endmodule // nsx_file_model

// ---- test/testbench.sv ----
// Self-checking bench for the nsx datapath, one task per scenario.
// Assumes the file model above stands on the file side.
`timescale 1ns/1ps
module testbench;
	import nsx_pkg::*;
	logic sys_clk = 0, rst = 1, opValid = 0, destSel = 0, zeroFlag, fileWe;
	nsx_op_type opCode = nibble_exchange_op;
	logic [6:0] fileAddr = 7'h00, fileWaddr;
	logic [7:0] literalValue = 8'h00, fileRdata, workValue, dirA, dirB, dirC, fileWdata;
	int bad_count = 0, tests_run = 0;
	nsx_datapath dut_u (.sys_clk, .rst, .opValid, .opCode, .destSel, .fileAddr, .literalValue,
		.fileRdata, .workValue, .zeroFlag, .portADirection(dirA), .portBDirection(dirB),
		.portCDirection(dirC), .fileWe, .fileWaddr, .fileWdata);
	nsx_file_model mem_u (.sys_clk, .fileAddr, .fileRdata, .fileWe, .fileWaddr, .fileWdata);
	initial forever #2.5 sys_clk = ~sys_clk;
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One op per call, with an idle cycle after it; sampled once the take edge has landed
	task automatic run_op(nsx_op_type op, logic d, logic [6:0] a, logic [7:0] k);
		@(posedge sys_clk);
		opValid <= 1'b1;
		opCode <= op;
		destSel <= d;
		fileAddr <= a;
		literalValue <= k;
		@(posedge sys_clk);
		opValid <= 1'b0;
		#1;
	endtask
	task automatic t_lit;
		run_op(xor_literal_op, 1'b1, 7'h00, 8'h5A);
		chk("work", workValue, 8'h5A);
		chk("zero", 8'(zeroFlag), 8'h00);
		run_op(xor_literal_op, 1'b0, 7'h00, 8'h5A);
		chk("work", workValue, 8'h00);
		chk("zero", 8'(zeroFlag), 8'h01);
	endtask
	task automatic t_file;
		run_op(xor_literal_op, 1'b0, 7'h00, 8'hC3);
		mem_u.store[3] = 8'h0F;
		mem_u.store[127] = 8'hCC;
		run_op(xor_file_op, 1'b0, 7'h03, 8'h00);
		chk("work", workValue, 8'hCC);
		chk("we", 8'(fileWe), 8'h00);
		run_op(xor_file_op, 1'b1, 7'h7F, 8'h00);
		chk("we", 8'(fileWe), 8'h01);
		chk("waddr", 8'(fileWaddr), 8'h7F);
		chk("wdata", fileWdata, 8'h00);
		chk("work", workValue, 8'hCC);
		chk("zero", 8'(zeroFlag), 8'h01);
	endtask
	task automatic t_swap;
		mem_u.store[9] = 8'h1E;
		run_op(nibble_exchange_op, 1'b0, 7'h09, 8'h00);
		chk("work", workValue, 8'hE1);
		chk("zero", 8'(zeroFlag), 8'h01);
		run_op(nibble_exchange_op, 1'b1, 7'h09, 8'h00);
		chk("wdata", fileWdata, 8'hE1);
		chk("we", 8'(fileWe), 8'h01);
	endtask
	// Operand 4 goes first, so a loose decode would disturb a direction early
	task automatic t_dir;
		logic [7:0] w;
		w = 8'hE1;
		for (int f = 4; f < 8; f++) begin
			run_op(xor_literal_op, 1'b0, 7'h00, w ^ 8'(8'h10 + f));
			w = 8'(8'h10 + f);
			run_op(direction_load_op, 1'b1, 7'(f), 8'h00);
			chk("dirA", dirA, f >= 5 ? 8'h15 : 8'hFF);
			chk("dirB", dirB, f >= 6 ? 8'h16 : 8'hFF);
			chk("dirC", dirC, f >= 7 ? 8'h17 : 8'hFF);
			chk("zero", 8'(zeroFlag), 8'h00);
		end
		run_op(direction_load_op, 1'b0, 7'h0D, 8'h00);
		chk("dirA", dirA, 8'h15);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk("work", workValue, 8'h00);
		chk("dirC", dirC, 8'hFF);
		t_lit;
		t_file;
		t_swap;
		t_dir;
		close_out;
	end
endmodule // testbench
